// File: src/csrx_core.sv
// Clocked serial port core: receive and full-duplex modes.
// Assumes a one-cycle register port master on clk_sys_i; pins asynchronous.
module csrx_core (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oen_o,
	output logic so_o,
	input wire logic si_i,
	output logic irq_o
);
	csrx_pkg::csrx_state_t s_r, s_nxt;
	logic ext_w, sck_now, sck_prev, rise_w, fall_w, tx_edge, rx_edge;
	logic tog_w;
	logic wr_ctrl, wr_buf, rd_buf, rd_stat, active_w;

	// Clock edge pick, external needs two stages before any use
	always_comb begin
		ext_w = (s_r.ctrl.cks == csrx_pkg::CSRX_CKS_EXT);
		sck_now = s_r.sck_s[1];
		sck_prev = s_r.sck_s[2];
		// Internal edge is flagged in the cycle the pin is about to toggle
		tog_w = s_r.div == 8'h00 && s_r.st.shift && !ext_w;
		rise_w = ext_w ? (sck_now & ~sck_prev) : (tog_w & ~s_r.sck_int);
		fall_w = ext_w ? (~sck_now & sck_prev) : (tog_w & s_r.sck_int);
		// Edge 0: out on falling, in on rising
		tx_edge = s_r.ctrl.edge_sel ? rise_w : fall_w;
		rx_edge = s_r.ctrl.edge_sel ? fall_w : rise_w;
		wr_ctrl = wr_i && addr_i == csrx_pkg::CSRX_ADDR_CTRL;
		wr_buf = wr_i && addr_i == csrx_pkg::CSRX_ADDR_BUF;
		rd_buf = rd_i && addr_i == csrx_pkg::CSRX_ADDR_BUF;
		rd_stat = rd_i && addr_i == csrx_pkg::CSRX_ADDR_STAT;
		active_w = s_r.st.shift;
	end

	// Divider reload, one less than the half-period length, from clock source select
	function automatic logic [7:0] half_len(input logic [2:0] cks);
		return 8'((csrx_pkg::CSRX_HALF_BASE << (3'h6 - cks)) - 8'h01);
	endfunction

	// Bit order chosen at the shifter; both ends use the same direction
	function automatic logic out_bit(input logic [7:0] v, input logic dir);
		return dir ? v[7] : v[0];
	endfunction

	always_comb begin
		logic byte_end;
		logic [7:0] shin;
		logic udr_set;
		byte_end = 1'b0;
		udr_set = 1'b0;
		shin = 8'h00;
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.sck_s = {s_r.sck_s[1:0], sck_i};
		s_nxt.si_s = {s_r.si_s[0], si_i};

		// Internal clock divider runs only while shifting
		if (!ext_w && s_r.st.shift) begin
			if (s_r.div == 8'h00) begin
				s_nxt.div = half_len(s_r.ctrl.cks);
				s_nxt.sck_int = ~s_r.sck_int;
			end else begin
				s_nxt.div = s_r.div - 8'h01;
			end
		end else begin
			s_nxt.div = half_len(s_r.ctrl.cks);
			s_nxt.sck_int = ~s_r.ctrl.edge_sel; // idle level
		end

		// Shift engine, external clock runs whenever comm active
		if (s_r.st.comm && (s_r.st.shift || ext_w)) begin
			if (tx_edge && s_r.ctrl.mode == csrx_pkg::CSRX_MODE_TRX) begin
				if (!s_r.sh_full && ext_w && s_r.cnt == 4'h0) begin
					// Nothing new written: resend last buffered byte
					s_nxt.sh = s_r.buf_q;
					s_nxt.st.udr = 1'b1;
					udr_set = 1'b1;
					s_nxt.so = out_bit(s_r.buf_q, s_r.ctrl.dir);
				end else begin
					s_nxt.so = out_bit(s_r.sh, s_r.ctrl.dir);
				end
				s_nxt.sh_full = 1'b1;
				s_nxt.st.shift = 1'b1;
			end
			if (rx_edge) begin
				shin = s_r.ctrl.dir ? {s_r.sh[6:0], s_r.si_s[1]}
					: {s_r.si_s[1], s_r.sh[7:1]};
				s_nxt.sh = shin;
				s_nxt.st.shift = 1'b1;
				s_nxt.cnt = s_r.cnt + 4'h1;
				if (s_r.cnt == csrx_pkg::CSRX_BITS - 4'h1) begin
					byte_end = 1'b1;
					s_nxt.cnt = csrx_pkg::CSRX_CNT_RST;
				end
			end
		end

		// Byte completion
		if (byte_end) begin
			s_nxt.irq = 1'b1;
			s_nxt.sh_full = 1'b0;
			if (s_r.st.rxdone) begin
				s_nxt.st.ovr = 1'b1;
			end else begin
				s_nxt.buf_q = shin;
			end
			s_nxt.st.rxdone = 1'b1;
			if (s_r.ctrl.mode == csrx_pkg::CSRX_MODE_TRX) begin
				s_nxt.st.shift = 1'b0;
				if (s_r.st.tx_buffer_full_flag && !ext_w && !s_r.stop_req) begin
					s_nxt.st.tx_buffer_full_flag = 1'b0;
					s_nxt.sh = s_r.buf_q;
					s_nxt.sh_full = 1'b1;
					s_nxt.st.shift = 1'b1;
				end else if (!ext_w) begin
					s_nxt.so = 1'b1;
				end
			end else begin
				// Internal clock waits for a buffer read
				s_nxt.st.shift = ext_w;
			end
			if (s_r.stop_req) begin
				s_nxt.st.comm = 1'b0;
				s_nxt.st.shift = 1'b0;
				s_nxt.st.tx_buffer_full_flag = 1'b0;
				s_nxt.stop_req = 1'b0;
				if (!ext_w) begin
					s_nxt.so = 1'b1;
				end
			end
		end

		// Reads: side effects on flags, set above wins
		if (rd_buf) begin
			if (!byte_end) begin
				s_nxt.st.rxdone = 1'b0;
			end
			if (s_r.ctrl.mode == csrx_pkg::CSRX_MODE_RX && s_r.st.comm &&
				!ext_w && !s_r.stop_req) begin
				s_nxt.st.shift = 1'b1;
			end
		end
		if (rd_stat && !(byte_end && s_r.st.rxdone)) begin
			s_nxt.st.ovr = 1'b0;
		end
		// Underrun set in the same cycle wins over the clearing read
		if (rd_stat && !udr_set) begin
			s_nxt.st.udr = 1'b0;
		end

		// Buffer write
		if (wr_buf) begin
			if (s_r.st.comm && s_r.ctrl.mode == csrx_pkg::CSRX_MODE_TRX &&
				!s_nxt.sh_full && !s_r.st.shift) begin
				s_nxt.sh = wdata_i;
				s_nxt.sh_full = 1'b1;
				s_nxt.st.shift = 1'b1;
				s_nxt.st.udr = s_nxt.st.udr;
			end else begin
				s_nxt.buf_q = wdata_i;
				if (s_r.st.comm) begin
					s_nxt.st.tx_buffer_full_flag = 1'b1;
				end
			end
		end

		// Control write
		if (wr_ctrl) begin
			if (wdata_i[1:0] == csrx_pkg::CSRX_MODE_OFF) begin
				// Forced stop regardless of shift state
				s_nxt.ctrl = csrx_ctrl_from(wdata_i);
				s_nxt.ctrl.run = 1'b0;
				s_nxt.st = '0;
				s_nxt.so = 1'b1;
				s_nxt.cnt = csrx_pkg::CSRX_CNT_RST;
				s_nxt.sh_full = 1'b0;
				s_nxt.stop_req = 1'b0;
			end else if (s_r.st.comm) begin
				// Only the run bit may change while active
				if (!wdata_i[csrx_pkg::CSRX_CR_RUN]) begin
					s_nxt.ctrl.run = 1'b0;
					if (active_w && !byte_end) begin
						s_nxt.stop_req = 1'b1;
					end else begin
						s_nxt.st.comm = 1'b0;
						s_nxt.st.shift = 1'b0;
						s_nxt.st.tx_buffer_full_flag = 1'b0;
						s_nxt.cnt = csrx_pkg::CSRX_CNT_RST;
						if (!ext_w) begin
							s_nxt.so = 1'b1;
						end
					end
				end
			end else begin
				s_nxt.ctrl = csrx_ctrl_from(wdata_i);
				if (wdata_i[csrx_pkg::CSRX_CR_RUN]) begin
					s_nxt.st.comm = 1'b1;
					s_nxt.st.shift = 1'b1;
					s_nxt.cnt = csrx_pkg::CSRX_CNT_RST;
					if (wdata_i[1:0] == csrx_pkg::CSRX_MODE_TRX) begin
						s_nxt.sh = s_r.buf_q;
						s_nxt.sh_full = 1'b1;
						s_nxt.irq = 1'b1;
					end
					// Mode 10 leaves the transmitter idle high
					if (wdata_i[1:0] == csrx_pkg::CSRX_MODE_RX) begin
						s_nxt.so = 1'b1;
					end
				end
			end
		end

		// Read data
		case (addr_i)
			csrx_pkg::CSRX_ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
			csrx_pkg::CSRX_ADDR_STAT: s_nxt.rdata = {2'h0, s_r.st};
			csrx_pkg::CSRX_ADDR_BUF: s_nxt.rdata = s_r.buf_q;
			default: s_nxt.rdata = 8'h00;
		endcase
		if (!rd_i) begin
			s_nxt.rdata = 8'h00;
		end
	end

	// Unpack a control write into its fields
	function automatic csrx_pkg::csrx_ctrl_t csrx_ctrl_from(
		input logic [7:0] w);
		return csrx_pkg::csrx_ctrl_t'(w);
	endfunction

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '0;
			s_r.ctrl <= csrx_pkg::csrx_ctrl_t'(csrx_pkg::CSRX_CTRL_RST);
			s_r.buf_q <= csrx_pkg::CSRX_BUF_RST;
			s_r.so <= 1'b1;
			s_r.sck_int <= 1'b1;
			s_r.div <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Pin drive; enable is low while we drive the clock
	always_comb begin
		rdata_o = s_r.rdata;
		sck_o = s_r.sck_int;
		sck_oen_o = ext_w;
		so_o = s_r.so;
		irq_o = s_r.irq;
	end

	AST_FORCE_STOP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		wr_ctrl && wdata_i[1:0] == 2'h0 |=> s_r.st == '0 && !s_r.ctrl.run)
		else $error("forced stop left status set");
	AST_DUPLEX_HIGH: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		wr_ctrl && wdata_i[1:0] == 2'h0 |=> so_o)
		else $error("data out not high after forced stop");
	AST_RD_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		rd_buf && !byte_end_chk() |=> !s_r.st.rxdone)
		else $error("buffer read did not clear rx done");
	AST_LOCKED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_r.st.comm && wr_ctrl && wdata_i[1:0] != 2'h0
		|=> $stable(s_r.ctrl.cks) && $stable(s_r.ctrl.dir))
		else $error("locked field changed while active");
	AST_START: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!s_r.st.comm && wr_ctrl && wdata_i[7] && wdata_i[1:0] != 2'h0
		|=> s_r.st.comm && s_r.st.shift)
		else $error("start did not set active flags");
	AST_TRX_IRQ: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!s_r.st.comm && wr_ctrl && wdata_i[7] && wdata_i[1:0] == 2'h3
		|=> irq_o)
		else $error("duplex start without irq");
	AST_CLK_DIR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		sck_oen_o == (s_r.ctrl.cks == 3'h7))
		else $error("clock pin direction wrong");
	AST_STAT_OVR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		s_r.st.ovr && rd_stat && !byte_end_chk() |=> !s_r.st.ovr)
		else $error("status read did not clear overrun");

	// Helper: byte completion in the current cycle
	function automatic logic byte_end_chk();
		return s_r.st.comm && rx_edge &&
			s_r.cnt == 4'h7 && (s_r.st.shift || ext_w);
	endfunction
endmodule

// File: src/csrx_pkg.sv
// Constants, register map and carrier types of the clocked serial port.
// Assumes a plain register port on clk_sys_i and a link sampled in-domain.
package csrx_pkg;
	localparam logic [1:0] CSRX_ADDR_CTRL = 2'h0;
	localparam logic [1:0] CSRX_ADDR_STAT = 2'h1;
	localparam logic [1:0] CSRX_ADDR_BUF = 2'h2;
	localparam logic [1:0] CSRX_MODE_OFF = 2'h0;
	localparam logic [1:0] CSRX_MODE_RX = 2'h2;
	localparam logic [1:0] CSRX_MODE_TRX = 2'h3;
	localparam logic [2:0] CSRX_CKS_EXT = 3'h7;
	// Control field positions
	localparam int CSRX_CR_RUN = 7;
	localparam int CSRX_CR_EDGE = 6;
	localparam int CSRX_CR_DIR = 5;
	localparam int CSRX_CR_CKS = 2;
	localparam int CSRX_CR_MODE = 0;
	localparam logic [7:0] CSRX_CTRL_RST = 8'h00;
	localparam logic [7:0] CSRX_BUF_RST = 8'h00;
	localparam logic [3:0] CSRX_BITS = 4'h8;
	// Half period of internal clock in sys cycles at select 6, doubling per step down
	localparam logic [7:0] CSRX_HALF_BASE = 8'h01;
	localparam logic [3:0] CSRX_CNT_RST = 4'h0;

	typedef struct packed {
		logic run;
		logic edge_sel;
		logic dir;
		logic [2:0] cks;
		logic [1:0] mode;
	} csrx_ctrl_t;

	typedef struct packed {
		logic comm;
		logic shift;
		logic rxdone;
		logic ovr;
		logic udr;
		logic tx_buffer_full_flag;
	} csrx_stat_t;

	typedef struct packed {
		csrx_ctrl_t ctrl;
		csrx_stat_t st;
		logic [7:0] buf_q;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic sh_full;
		logic stop_req;
		logic [7:0] div;
		logic sck_int;
		logic so;
		logic [2:0] sck_s;
		logic [1:0] si_s;
		logic irq;
		logic [7:0] rdata;
	} csrx_state_t;
endpackage

// File: dv/csrx_peer.sv
// Far-side serial peer: drives the data-in line, clocks when external.
// Assumes edge select 0: idle high, data moves on falling, sampled rising.
module csrx_peer (
	input wire logic dev_sck_i,
	input wire logic dev_oen_i,
	input wire logic dev_so_i,
	input wire logic msb_i,
	output logic sck_o,
	output logic si_o,
	output logic [7:0] rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	logic clk_w;
	// Whichever party owns the clock pin clocks the peer
	assign clk_w = dev_oen_i ? sck_o : dev_sck_i;
	initial begin
		sck_o = 1'b1;
		si_o = 1'b0;
		rx_o = 8'h00;
		sh = 8'h00;
	end
	// First bit must stand before the first sample edge
	task automatic load(input logic [7:0] b);
		sh = b;
		si_o = msb_i ? b[7] : b[0];
	endtask
	// External clock runs only inside a frame, then stands idle high
	task automatic burst();
		repeat (8) begin
			#40 sck_o = 1'b0;
			#40 sck_o = 1'b1;
		end
	endtask
	// Capture device data on rising edge, advance own shifter
	always @(posedge clk_w) begin
		rx_o = msb_i ? {rx_o[6:0], dev_so_i} : {dev_so_i, rx_o[7:1]};
		sh = msb_i ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
	end
	// Next bit goes out on the falling edge
	always @(negedge clk_w) begin
		si_o = msb_i ? sh[7] : sh[0];
	end
endmodule

// File: dv/tb_csrx_core.sv
// Self-checking bench for the serial port core with a behavioural peer.
// Assumes the register map and status layout of the package.
module tb_csrx_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic msb = 1'b1;
	logic [7:0] rdata, p_rx, s, b, p;
	logic sck_pin, sck_o, sck_oen, so, si, irq;
	int mismatches = 0;
	int num_checks = 0;
	int seed = 33;
	csrx_core u_csrx_core (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
		.rdata_o(rdata), .sck_i(sck_pin), .sck_o(sck_o),
		.sck_oen_o(sck_oen), .so_o(so), .si_i(si), .irq_o(irq));
	csrx_peer u_csrx_peer (.dev_sck_i(sck_o), .dev_oen_i(sck_oen),
		.dev_so_i(so), .msb_i(msb), .sck_o(sck_pin), .si_o(si),
		.rx_o(p_rx));
	always #5 clk_sys_i = ~clk_sys_i;
	// Status byte from its flags, in register order
	function automatic logic [7:0] st(input logic c, sh, rx, ov);
		return {2'h0, c, sh, rx, ov, 2'h0};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_sys_i);
		wr_s <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_sys_i);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	// Bounded wait for the one-cycle interrupt pulse
	task automatic wait_irq();
		logic seen;
		seen = 1'b0;
		// Look first: the pulse may start at the edge just passed
		for (int i = 0; i < 2000 && !seen; i++) begin
			#1 seen = (irq === 1'b1);
			if (!seen)
				@(posedge clk_sys_i);
		end
		@(posedge clk_sys_i);
		check({7'h0, seen}, 8'h01);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#200000 mismatches++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		// Reset values and the unmapped index
		for (int a = 0; a < 4; a++) begin
			rd(a[1:0], s);
			check(s, 8'h00);
		end
		check({7'h0, so}, 8'h01);
		$display("reset test done");
		// Receive with internal clock, both bit orders
		for (int d = 1; d >= 0; d--) begin
			msb = d[0];
			b = $random(seed);
			u_csrx_peer.load(b);
			wr(2'h0, {1'b1, 1'b0, d[0], 3'h2, 2'h2});
			rd(2'h1, s);
			check(s, st(1, 1, 0, 0));
			check({7'h0, sck_oen}, 8'h00);
			wait_irq();
			rd(2'h1, s);
			check(s, st(1, 0, 1, 0));
			rd(2'h2, s);
			check(s, b);
			rd(2'h1, s);
			check(s, st(1, 1, 0, 0));
			wr(2'h0, {1'b1, 1'b1, ~d[0], 3'h7, 2'h2});
			rd(2'h0, s);
			check(s, {1'b1, 1'b0, d[0], 3'h2, 2'h2});
			wr(2'h0, 8'h00);
			rd(2'h1, s);
			check(s, 8'h00);
			rd(2'h0, s);
			check(s & 8'h80, 8'h00);
			check({7'h0, sck_o}, 8'h01);
		end
		$display("receive internal test done");
		// Full duplex, internal clock, then stop while idle
		msb = 1'b1;
		b = $random(seed);
		p = $random(seed);
		u_csrx_peer.load(p);
		wr(2'h2, b);
		wr(2'h0, 8'hAB);
		wait_irq();
		wait_irq();
		check(p_rx, b);
		rd(2'h1, s);
		check(s, st(1, 0, 1, 0));
		check({7'h0, so}, 8'h01);
		rd(2'h2, s);
		check(s, p);
		wr(2'h0, 8'h2B);
		repeat (50) begin
			@(posedge clk_sys_i);
			#1 check({7'h0, irq}, 8'h00);
		end
		rd(2'h1, s);
		check(s, 8'h00);
		wr(2'h0, 8'h00);
		$display("duplex internal test done");
		// Receive with external clock: late read gives overrun
		b = $random(seed);
		p = $random(seed);
		wr(2'h0, 8'hBE);
		#1 check({7'h0, sck_oen}, 8'h01);
		u_csrx_peer.load(b);
		u_csrx_peer.burst();
		wait_irq();
		#200 u_csrx_peer.load(p);
		u_csrx_peer.burst();
		repeat (20) @(posedge clk_sys_i);
		rd(2'h1, s);
		check(s & 8'h2C, 8'h2C);
		rd(2'h2, s);
		check(s, b);
		rd(2'h1, s);
		check(s & 8'h04, 8'h00);
		wr(2'h0, 8'h00);
		rd(2'h1, s);
		check(s, 8'h00);
		$display("receive external test done");
		final_report();
	end
endmodule
